// >>> src/thermal_window_alarm_pkg.sv
// Constants and types shared by the thermal window alarm slave
package thermal_window_alarm_pkg;
  // Clock and timing
  localparam int CLK_HZ = 125_000_000;
  localparam int TIMEOUT_MS = 75;
  localparam int TIMEOUT_CYCLES = TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int CONV_CYCLES = 20000;
  localparam int CNT_W = 24;

  // Fixed upper part of the 7-bit slave address
  localparam logic [4:0] ADDR_FIXED = 5'h12;

  // Register selector codes
  localparam logic [2:0] PTR_TEMP = 3'h0;
  localparam logic [2:0] PTR_CFG = 3'h1;
  localparam logic [2:0] PTR_HYST = 3'h2;
  localparam logic [2:0] PTR_CRIT = 3'h3;
  localparam logic [2:0] PTR_LOW = 3'h4;
  localparam logic [2:0] PTR_HIGH = 3'h5;
  localparam logic [2:0] PTR_ID = 3'h7;

  // Configuration bit positions
  localparam int CFG_W = 5;
  localparam int CFG_SHUTDOWN = 0;
  localparam int CFG_EVENT_MODE = 1;
  localparam int CFG_CRIT_POL = 2;
  localparam int CFG_WIN_POL = 3;
  localparam int CFG_FAULT_QUEUE = 4;
  localparam logic [4:0] CFG_RESET = 5'h00;

  // Temperature words: 13-bit two's complement, 1/16 degree steps
  localparam int TEMP_W = 13;
  localparam logic [12:0] LOW_RESET = 13'h00A0;
  localparam logic [12:0] HIGH_RESET = 13'h0400;
  localparam logic [12:0] CRIT_RESET = 13'h0500;
  localparam logic [12:0] HYST_RESET = 13'h0020;

  // Status flag indices and fault queue depth
  localparam int FLAG_LOW = 0;
  localparam int FLAG_HIGH = 1;
  localparam int FLAG_CRIT = 2;
  localparam logic [2:0] FAULT_DEPTH = 3'h4;

  // Arbitrary identification value
  localparam logic [15:0] DEVICE_ID = 16'h5A5A;

  typedef enum logic [5:0] {
    S_IDLE = 6'h01,
    S_ADDR = 6'h02,
    S_ACK = 6'h04,
    S_WRITE = 6'h08,
    S_READ = 6'h10,
    S_RACK = 6'h20
  } bus_state_t;
endpackage

// >>> src/thermal_window_alarm_slave.sv
// Two-wire slave with window and critical temperature comparator
`timescale 1ns/10ps

// How it works
// [R1] Critical output mirrors critical flag except in shutdown
// [R2] Read keeps critical output, restarts conversion
// [R3] Comparator mode: read clears, reassert next conversion
// [R4] Comparator alert holds until above low+hysteresis
// [R5] Event mode: set per event until read
// [R6] Event is limit crossing or hysteresis return
// [R7] After read, low event waits for recovery
// [R8] Any register read restarts the conversion
// [R9] Host keeps hysteresis bands from overlapping
// [R10] Power-on defaults: comparator, 10/64/80/2, low
// [R11] Selector resets to temperature, holds last write
// [R12] Slave address 10010 plus two select pins
// [R13] Temperatures are 13-bit, sixteenth degree steps
// [R14] Frequent reads prevent result updates
// [R15] Shutdown stops conversions, silences alarm outputs
// [R16] Fault queue needs four consecutive conversions
// [R17] All registers writable except temperature and ID
// [R18] Host writes address, selector, then data
// [R19] Host reads current or reselects via restart
// [R20] Most significant byte and bit first
// [R21] Accept ack or nack after last byte
// [R22] Stuck data low recovered by extra clocks
// [R23] Flags clear only past the hysteresis point
// [R24] Mode bit: 0 comparator, 1 event
// [R25] Polarity bit: 0 active low, 1 high
// [R26] Long low bus returns interface to idle
// [R27] Conversion period parameter; read restarts it
module thermal_window_alarm_slave #(
  parameter int CONV_CYCLES = thermal_window_alarm_pkg::CONV_CYCLES,
  parameter int TIMEOUT_CYCLES = thermal_window_alarm_pkg::TIMEOUT_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Serial bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Address select straps
  input wire logic addr_select_lo,
  input wire logic addr_select_hi,
  // Converter result, valid at every conversion end
  input wire logic [12:0] conversion_result,
  // Open-drain alarm outputs
  output logic window_alert_out,
  output logic window_alert_oe,
  output logic critical_alarm_out,
  output logic critical_alarm_oe
);
  localparam int TW = thermal_window_alarm_pkg::TEMP_W;
  localparam logic [23:0] CONV_LAST = 24'(CONV_CYCLES - 1);
  localparam logic [23:0] TIMEOUT_LAST = 24'(TIMEOUT_CYCLES - 1);

  thermal_window_alarm_pkg::bus_state_t state;
  logic [1:0] scl_sync, sda_sync, sel_lo_sync, sel_hi_sync;
  logic scl_d, sda_d;
  logic [7:0] shift;
  logic [3:0] bit_cnt;
  logic rw, rd_second;
  logic [1:0] wr_idx;
  logic [7:0] wr_msb;
  logic [2:0] pointer;
  logic sda_drive;
  logic read_start, reg_we;
  logic [15:0] reg_wdata;
  logic [15:0] read_word;
  logic [7:0] tx_byte;
  logic [23:0] low_cnt, conv_cnt;
  logic timeout, conv_end;
  logic [4:0] cfg;
  logic [12:0] limit_low, limit_high, limit_crit, hysteresis_amount;
  logic [12:0] temp_result;
  logic [2:0] flag, flip, cond_set, cond_clr;
  logic [2:0] fq_cnt [3];
  logic [2:0] fq_need;
  logic win_alert, win_event;
  logic signed [13:0] t, lo_pt, hi_pt, cr_pt;

  wire scl_s = scl_sync[1];
  wire sda_s = sda_sync[1];
  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  wire bus_start = scl_s & scl_d & sda_d & ~sda_s;
  wire bus_stop = scl_s & scl_d & ~sda_d & sda_s;
  wire shutdown = cfg[thermal_window_alarm_pkg::CFG_SHUTDOWN];
  wire event_mode = cfg[thermal_window_alarm_pkg::CFG_EVENT_MODE];

  // Pins cross two flops before any logic looks at them
  always_ff @(posedge clk) begin
    scl_sync <= {scl_sync[0], scl_in};
    sda_sync <= {sda_sync[0], sda_in};
    sel_lo_sync <= {sel_lo_sync[0], addr_select_lo};
    sel_hi_sync <= {sel_hi_sync[0], addr_select_hi};
    scl_d <= scl_s;
    sda_d <= sda_s;
  end

  // Bus stuck low watchdog
  always_ff @(posedge clk) begin
    if (srst || (scl_s && sda_s)) begin
      low_cnt <= 24'h00_0000;
    end else if (!timeout) begin
      low_cnt <= low_cnt + 24'h00_0001;
    end
  end
  assign timeout = (low_cnt == TIMEOUT_LAST); // [R26]

  // Selected register as a 16-bit word
  always_comb begin
    unique case (pointer)
      thermal_window_alarm_pkg::PTR_TEMP:
        read_word = {temp_result, flag}; // [R13]
      thermal_window_alarm_pkg::PTR_CFG:
        read_word = {3'h0, cfg, 8'h00};
      thermal_window_alarm_pkg::PTR_HYST:
        read_word = {hysteresis_amount, 3'h0};
      thermal_window_alarm_pkg::PTR_CRIT:
        read_word = {limit_crit, 3'h0};
      thermal_window_alarm_pkg::PTR_LOW:
        read_word = {limit_low, 3'h0};
      thermal_window_alarm_pkg::PTR_HIGH:
        read_word = {limit_high, 3'h0};
      thermal_window_alarm_pkg::PTR_ID:
        read_word = thermal_window_alarm_pkg::DEVICE_ID;
      default:
        read_word = 16'h0000;
    endcase
    tx_byte = rd_second ? read_word[7:0] : read_word[15:8]; // [R20]
  end

  // Serial slave state machine
  always_ff @(posedge clk) begin
    read_start <= 1'b0;
    reg_we <= 1'b0;
    if (srst || timeout) begin // [R26]
      state <= thermal_window_alarm_pkg::S_IDLE;
      sda_drive <= 1'b0;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      rw <= 1'b0;
      rd_second <= 1'b0;
      wr_idx <= 2'h0;
      wr_msb <= 8'h00;
      reg_wdata <= 16'h0000;
      if (srst) begin
        pointer <= thermal_window_alarm_pkg::PTR_TEMP; // [R11]
      end
    end else if (bus_start) begin
      state <= thermal_window_alarm_pkg::S_ADDR;
      sda_drive <= 1'b0;
      bit_cnt <= 4'h0;
    end else if (bus_stop) begin
      state <= thermal_window_alarm_pkg::S_IDLE;
      sda_drive <= 1'b0;
    end else begin
      unique case (state)
        thermal_window_alarm_pkg::S_IDLE: begin
          sda_drive <= 1'b0;
        end
        thermal_window_alarm_pkg::S_ADDR,
        thermal_window_alarm_pkg::S_WRITE: begin
          if (scl_rise) begin
            shift <= {shift[6:0], sda_s};
            bit_cnt <= bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == 4'h8) begin
            bit_cnt <= 4'h0;
            sda_drive <= 1'b1;
            state <= thermal_window_alarm_pkg::S_ACK;
            if (state == thermal_window_alarm_pkg::S_ADDR) begin
              if (shift[7:1] == {thermal_window_alarm_pkg::ADDR_FIXED,
                                 sel_hi_sync[1], sel_lo_sync[1]}) begin // [R12]
                rw <= shift[0];
                rd_second <= 1'b0;
                wr_idx <= 2'h0;
                read_start <= shift[0]; // [R8]
              end else begin
                sda_drive <= 1'b0;
                state <= thermal_window_alarm_pkg::S_IDLE;
              end
            end else begin
              if (wr_idx != 2'h3) begin
                wr_idx <= wr_idx + 2'h1;
              end
              if (wr_idx == 2'h0) begin
                pointer <= shift[2:0]; // [R11]
              end else if (wr_idx == 2'h1) begin
                wr_msb <= shift;
                reg_we <= (pointer == thermal_window_alarm_pkg::PTR_CFG);
                reg_wdata <= {shift, 8'h00};
              end else if (wr_idx == 2'h2) begin
                reg_we <= (pointer != thermal_window_alarm_pkg::PTR_CFG);
                reg_wdata <= {wr_msb, shift};
              end
            end
          end
        end
        thermal_window_alarm_pkg::S_ACK: begin
          if (scl_fall) begin
            if (rw) begin
              sda_drive <= ~tx_byte[7]; // [R20]
              shift <= {tx_byte[6:0], 1'b0};
              rd_second <= ~rd_second;
              bit_cnt <= 4'h1;
              state <= thermal_window_alarm_pkg::S_READ;
            end else begin
              sda_drive <= 1'b0;
              bit_cnt <= 4'h0;
              state <= thermal_window_alarm_pkg::S_WRITE;
            end
          end
        end
        thermal_window_alarm_pkg::S_READ: begin
          if (scl_fall) begin
            if (bit_cnt == 4'h8) begin
              sda_drive <= 1'b0; // [R22]
              state <= thermal_window_alarm_pkg::S_RACK;
            end else begin
              sda_drive <= ~shift[7];
              shift <= {shift[6:0], 1'b0};
              bit_cnt <= bit_cnt + 4'h1;
            end
          end
        end
        thermal_window_alarm_pkg::S_RACK: begin
          if (scl_rise) begin
            // Nack ends the read quietly; the stop follows
            state <= sda_s ? thermal_window_alarm_pkg::S_IDLE
                           : thermal_window_alarm_pkg::S_ACK; // [R21]
          end
        end
      endcase
    end
  end
  assign sda_out = 1'b0;
  assign sda_oe = sda_drive;

  // Programmable registers; temperature result has no write path
  always_ff @(posedge clk) begin
    if (srst) begin
      cfg <= thermal_window_alarm_pkg::CFG_RESET; // [R10]
      limit_low <= thermal_window_alarm_pkg::LOW_RESET;
      limit_high <= thermal_window_alarm_pkg::HIGH_RESET;
      limit_crit <= thermal_window_alarm_pkg::CRIT_RESET;
      hysteresis_amount <= thermal_window_alarm_pkg::HYST_RESET;
    end else if (reg_we) begin // [R17]
      unique case (pointer)
        thermal_window_alarm_pkg::PTR_CFG: cfg <= reg_wdata[12:8];
        thermal_window_alarm_pkg::PTR_HYST:
          hysteresis_amount <= reg_wdata[15:3];
        thermal_window_alarm_pkg::PTR_CRIT: limit_crit <= reg_wdata[15:3];
        thermal_window_alarm_pkg::PTR_LOW: limit_low <= reg_wdata[15:3];
        thermal_window_alarm_pkg::PTR_HIGH: limit_high <= reg_wdata[15:3];
        default: cfg <= cfg;
      endcase
    end
  end

  // Conversion timer; a read or shutdown restarts it
  always_ff @(posedge clk) begin
    if (srst || shutdown || read_start || conv_end) begin // [R27]
      conv_cnt <= 24'h00_0000;
    end else begin
      conv_cnt <= conv_cnt + 24'h00_0001;
    end
  end
  assign conv_end = !shutdown && !read_start
                    && conv_cnt == CONV_LAST; // [R14]

  always_ff @(posedge clk) begin
    if (srst) begin
      temp_result <= 13'h0000;
    end else if (conv_end) begin
      temp_result <= conversion_result; // [R27]
    end
  end

  // Trip and release points, with hysteresis
  always_comb begin
    t = {conversion_result[TW-1], conversion_result};
    lo_pt = 14'({limit_low[TW-1], limit_low}
            + {hysteresis_amount[TW-1], hysteresis_amount});
    hi_pt = 14'({limit_high[TW-1], limit_high}
            - {hysteresis_amount[TW-1], hysteresis_amount});
    cr_pt = 14'({limit_crit[TW-1], limit_crit}
            - {hysteresis_amount[TW-1], hysteresis_amount});
    cond_set[thermal_window_alarm_pkg::FLAG_LOW] =
      t < $signed({limit_low[TW-1], limit_low});
    cond_set[thermal_window_alarm_pkg::FLAG_HIGH] =
      t > $signed({limit_high[TW-1], limit_high});
    cond_set[thermal_window_alarm_pkg::FLAG_CRIT] =
      t > $signed({limit_crit[TW-1], limit_crit});
    cond_clr[thermal_window_alarm_pkg::FLAG_LOW] = t > lo_pt; // [R23]
    cond_clr[thermal_window_alarm_pkg::FLAG_HIGH] = t < hi_pt;
    cond_clr[thermal_window_alarm_pkg::FLAG_CRIT] = t < cr_pt;
  end

  // A flag flips once enough consecutive conversions agree
  assign fq_need = cfg[thermal_window_alarm_pkg::CFG_FAULT_QUEUE]
                   ? thermal_window_alarm_pkg::FAULT_DEPTH : 3'h1; // [R16]
  for (genvar i = 0; i < 3; i++) begin : g_flag
    wire want = flag[i] ? cond_clr[i] : cond_set[i];
    assign flip[i] = conv_end && want && (fq_cnt[i] + 3'h1 >= fq_need);
    always_ff @(posedge clk) begin
      if (srst) begin
        flag[i] <= 1'b0;
        fq_cnt[i] <= 3'h0;
      end else if (conv_end) begin
        flag[i] <= flag[i] ^ flip[i];
        fq_cnt[i] <= (want && !flip[i]) ? fq_cnt[i] + 3'h1 : 3'h0;
      end
    end
  end

  // Any flip of the window flags is an event
  assign win_event = flip[thermal_window_alarm_pkg::FLAG_LOW]
                     | flip[thermal_window_alarm_pkg::FLAG_HIGH]; // [R6]

  // Window alert; conversion end and read never coincide
  always_ff @(posedge clk) begin
    if (srst || shutdown) begin // [R15]
      win_alert <= 1'b0;
    end else if (conv_end) begin
      if (event_mode) begin // [R24]
        win_alert <= win_alert | win_event; // [R5] [R7]
      end else begin
        win_alert <= (flag[thermal_window_alarm_pkg::FLAG_LOW]
                     ^ flip[thermal_window_alarm_pkg::FLAG_LOW])
                   | (flag[thermal_window_alarm_pkg::FLAG_HIGH]
                     ^ flip[thermal_window_alarm_pkg::FLAG_HIGH]); // [R3] [R4]
      end
    end else if (read_start) begin
      win_alert <= 1'b0; // [R3]
    end
  end

  // Open drain: pulled low while enable is high
  always_ff @(posedge clk) begin
    if (srst) begin
      window_alert_oe <= 1'b0;
      critical_alarm_oe <= 1'b0;
    end else begin
      window_alert_oe <= win_alert
                         ^ cfg[thermal_window_alarm_pkg::CFG_WIN_POL]; // [R25]
      critical_alarm_oe <= (flag[thermal_window_alarm_pkg::FLAG_CRIT]
                            && !shutdown)
                           ^ cfg[thermal_window_alarm_pkg::CFG_CRIT_POL]; // [R1]
    end
  end
  assign window_alert_out = 1'b0;
  assign critical_alarm_out = 1'b0;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  property p_crit_follow;
    !shutdown && !$stable(flag[thermal_window_alarm_pkg::FLAG_CRIT])
    |=> critical_alarm_oe == (flag[thermal_window_alarm_pkg::FLAG_CRIT]
        ^ cfg[thermal_window_alarm_pkg::CFG_CRIT_POL]);
  endproperty
  a_crit_follow: assert property (p_crit_follow) // [R1]
    else $error("critical output does not follow its flag");

  property p_read_keeps_crit;
    read_start |=> $stable(flag[thermal_window_alarm_pkg::FLAG_CRIT]);
  endproperty
  a_read_keeps_crit: assert property (p_read_keeps_crit) // [R2]
    else $error("read changed the critical flag");

  property p_read_restart;
    read_start && !shutdown
    |=> conv_cnt == 24'h00_0000 ##1 conv_cnt == 24'h00_0001;
  endproperty
  a_read_restart: assert property (p_read_restart) // [R8]
    else $error("read did not restart the conversion");

  property p_read_clears;
    read_start && !shutdown |=> !win_alert ##1
      (window_alert_oe == cfg[thermal_window_alarm_pkg::CFG_WIN_POL]);
  endproperty
  a_read_clears: assert property (p_read_clears) // [R3]
    else $error("read did not clear the window alert");

  property p_event_sticky;
    event_mode && win_alert && !read_start && !shutdown
    && !$past(reg_we) |=> win_alert;
  endproperty
  a_event_sticky: assert property (p_event_sticky) // [R5]
    else $error("event alert dropped without a read");

  property p_shutdown_quiet;
    shutdown |-> !conv_end ##1 !win_alert;
  endproperty
  a_shutdown_quiet: assert property (p_shutdown_quiet) // [R15]
    else $error("activity during shutdown");

  property p_result_hold;
    !conv_end |=> $stable(temp_result);
  endproperty
  a_result_hold: assert property (p_result_hold) // [R14]
    else $error("result changed outside a conversion end");

  property p_flag_release;
    conv_end && flag[thermal_window_alarm_pkg::FLAG_HIGH]
    && !cond_clr[thermal_window_alarm_pkg::FLAG_HIGH]
    |=> flag[thermal_window_alarm_pkg::FLAG_HIGH];
  endproperty
  a_flag_release: assert property (p_flag_release) // [R23]
    else $error("high flag released inside hysteresis band");

  property p_timeout_idle;
    timeout |=> state == thermal_window_alarm_pkg::S_IDLE && !sda_oe;
  endproperty
  a_timeout_idle: assert property (p_timeout_idle) // [R26]
    else $error("bus timeout did not return to idle");
endmodule

// >>> verif/twa_bus_master.sv
// Two-wire bus master model that drives the slave's serial pins
`timescale 1ns/10ps
module twa_bus_master (
  // Bus wires
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  // Clock and data rest high between frames
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // Low phase 40 ns, high 24 ns: the slave answers some clocks after a fall
  task automatic clk_bit(input logic b, output logic r);
    #8 sda_low = ~b;
    #32 scl = 1'b1;
    #16 r = sda;
    #8 scl = 1'b0;
  endtask

  task automatic start;
    #3 sda_low = 1'b1;
    #16 scl = 1'b0;
  endtask

  task automatic restart;
    #8 sda_low = 1'b0;
    #16 scl = 1'b1;
    #16 sda_low = 1'b1;
    #16 scl = 1'b0;
  endtask

  task automatic stop;
    #8 sda_low = 1'b1;
    #16 scl = 1'b1;
    #16 sda_low = 1'b0;
    #16;
  endtask

  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) clk_bit(d[i], r);
    clk_bit(1'b1, r);
    ack = ~r;
  endtask

  // Master acknowledges every byte but the last, which is refused
  task automatic recv(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, r);
      d[i] = r;
    end
    clk_bit(last, r);
  endtask

  task automatic write(input logic [6:0] a, input logic [2:0] p,
                       input logic [15:0] d, input int n, output logic ack);
    logic k;
    start();
    send({a, 1'b0}, ack);
    send({5'h00, p}, k);
    if (n == 2) send(d[15:8], k);
    send(d[7:0], k);
    stop();
  endtask

  task automatic read(input logic [6:0] a, input logic use_ptr,
                      input logic [2:0] p, input int n,
                      output logic [15:0] d, output logic ack);
    logic k;
    logic [7:0] b;
    d = 16'h0000;
    ack = 1'b1;
    start();
    if (use_ptr) begin
      send({a, 1'b0}, ack);
      send({5'h00, p}, k);
      restart();
    end
    send({a, 1'b1}, k);
    ack = ack & k;
    if (k) begin
      for (int i = 0; i < n; i++) begin
        recv(i == n - 1, b);
        d = {d[7:0], b};
      end
    end
    stop();
  endtask
endmodule

// >>> verif/thermal_window_alarm_slave_test.sv
// Self-checking bench for the thermal window alarm slave
`timescale 1ns/10ps
module thermal_window_alarm_slave_test;
  localparam int CONV = 400;
  localparam int TMO = 500;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic addr_select_lo = 1'b1;
  logic addr_select_hi = 1'b0;
  logic [12:0] conversion_result = 13'h0190;
  logic scl, m_low, sda, sda_out, sda_oe;
  logic window_alert_out, window_alert_oe;
  logic critical_alarm_out, critical_alarm_oe;
  logic [31:0] lfsr = 32'h0f7d_60ec;
  logic [6:0] dev = {thermal_window_alarm_pkg::ADDR_FIXED, 2'b01};
  logic [15:0] exp_q[$];
  logic [15:0] obs, e_v, rd;
  logic [12:0] v;
  logic ack;
  event obs_ev;
  int error_cnt = 0;
  int check_count = 0;
  logic [2:0] tp[6] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h7};
  logic [15:0] tv[6] = '{16'h0000, 16'h0100, 16'h2800, 16'h0500,
                         16'h2000, thermal_window_alarm_pkg::DEVICE_ID};

  // Pull-up on the data wire: released means high
  assign sda = ~(m_low | (sda_oe & ~sda_out));

  always #4 clk = ~clk;

  thermal_window_alarm_slave #(
    .CONV_CYCLES(CONV),
    .TIMEOUT_CYCLES(TMO)
  ) DUT (
    .clk(clk), .srst(srst), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe),
    .addr_select_lo(addr_select_lo), .addr_select_hi(addr_select_hi),
    .conversion_result(conversion_result),
    .window_alert_out(window_alert_out), .window_alert_oe(window_alert_oe),
    .critical_alarm_out(critical_alarm_out),
    .critical_alarm_oe(critical_alarm_oe)
  );

  twa_bus_master mst (
    .sda(sda),
    .scl(scl),
    .sda_low(m_low)
  );

  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic note(input logic [15:0] e);
    exp_q.push_back(e);
  endtask

  task automatic observe(input logic [15:0] o);
    obs = o;
    ->obs_ev;
    #1;
  endtask

  task automatic set_temp(input logic [12:0] t);
    @(posedge clk);
    #1 conversion_result = t;
  endtask

  task automatic rd_chk(input logic use_ptr, input logic [2:0] p,
                        input int n, input logic [15:0] e);
    note(e);
    mst.read(dev, use_ptr, p, n, rd, ack);
    observe(rd);
  endtask

  // Pin order {critical, window}; oe high means the pin is pulled low
  task automatic pins(input logic [1:0] e, input int w);
    wait_clk(w);
    // Sample after the edge so the registered outputs have settled
    #1;
    note({14'h0000, e});
    observe({14'h0000, critical_alarm_oe, window_alert_oe});
  endtask

  // A read after every config write also restarts the conversion
  task automatic setcfg(input logic [4:0] c);
    mst.write(dev, 3'h1, {11'h000, c}, 1, ack);
    rd_chk(1'b1, 3'h1, 2, {3'b000, c, 8'h00});
  endtask

  task automatic print_verdict;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial forever begin
    @(obs_ev);
    e_v = (exp_q.size() > 0) ? exp_q.pop_front() : 16'hxxxx;
    check_count++;
    if (obs !== e_v) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, obs, e_v);
    end
  end

  initial begin
    wait_clk(100000);
    error_cnt++;
    $display("[FAIL] %0t watchdog expired", $time);
    print_verdict();
  end

  initial begin
    wait_clk(3);
    #1 srst = 1'b0;
    wait_clk(4);
    rd_chk(1'b0, 3'h0, 2, 16'h0000);
    for (int i = 0; i < 6; i++) rd_chk(1'b1, tp[i], 2, tv[i]);
    pins(2'b00, 1);
    rd_chk(1'b0, 3'h0, 2, tv[5]);
    @(posedge clk);
    #1 addr_select_lo = 1'b0;
    addr_select_hi = 1'b1;
    wait_clk(4);
    note(16'h0000);
    mst.read(dev, 1'b0, 3'h0, 2, rd, ack);
    observe({15'h0000, ack});
    dev = {thermal_window_alarm_pkg::ADDR_FIXED, 2'b10};
    wait_clk(900);
    mst.write(dev, 3'h0, 16'hfff8, 2, ack);
    rd_chk(1'b1, 3'h0, 2, 16'h0c80);
    for (int i = 0; i < 3; i++) begin
      lfsr = lfsr_next(lfsr);
      v = 13'h00d0 + {6'h00, lfsr[6:0]};
      set_temp(v);
      wait_clk(900);
      rd_chk(1'b0, 3'h0, 2, {v, 3'b000});
    end
    rd_chk(1'b0, 3'h0, 1, {8'h00, v[12:5]});
    set_temp(13'h0100);
    for (int i = 0; i < 4; i++) rd_chk(1'b0, 3'h0, 2, {v, 3'b000});
    // Low limit 20 degrees stays well clear of the upper band
    mst.write(dev, 3'h4, 16'h0a00, 2, ack);
    rd_chk(1'b1, 3'h4, 2, 16'h0a00);
    set_temp(13'h0130);
    pins(2'b01, 900);
    rd_chk(1'b1, 3'h0, 2, 16'h0981);
    pins(2'b00, 2);
    pins(2'b01, 900);
    set_temp(13'h0150);
    pins(2'b01, 900);
    set_temp(13'h0170);
    pins(2'b00, 900);
    set_temp(13'h0510);
    pins(2'b11, 900);
    rd_chk(1'b1, 3'h0, 2, 16'h2886);
    pins(2'b10, 2);
    setcfg(5'h0c);
    pins(2'b00, 900);
    set_temp(13'h0190);
    pins(2'b11, 900);
    setcfg(5'h00);
    pins(2'b00, 2);
    set_temp(13'h0510);
    pins(2'b11, 900);
    setcfg(5'h01);
    pins(2'b00, 10);
    pins(2'b00, 900);
    set_temp(13'h0190);
    setcfg(5'h00);
    pins(2'b00, 900);
    setcfg(5'h02);
    set_temp(13'h0130);
    pins(2'b01, 900);
    pins(2'b01, 900);
    rd_chk(1'b1, 3'h0, 2, 16'h0981);
    pins(2'b00, 2);
    pins(2'b00, 900);
    set_temp(13'h0170);
    pins(2'b01, 900);
    rd_chk(1'b1, 3'h0, 2, 16'h0b80);
    pins(2'b00, 2);
    setcfg(5'h10);
    set_temp(13'h0130);
    rd_chk(1'b1, 3'h0, 2, 16'h0b80);
    pins(2'b00, 1200);
    pins(2'b01, 400);
    // Stall a read with the slave pulling data low, then let SCL sit low
    mst.start();
    mst.send({dev, 1'b1}, ack);
    wait_clk(10);
    #1;
    note(16'h0001);
    observe({15'h0000, sda_oe});
    wait_clk(600);
    #1;
    note(16'h0000);
    observe({13'h0000, sda_oe, window_alert_out,
             critical_alarm_out});
    mst.stop();
    print_verdict();
  end
endmodule
